// File: rail_startup_sequencer_test.sv
`timescale 1ns/1ps
module rail_startup_sequencer_test;
    import rss_pkg::*;
    localparam int AON = 8, LEAD = 20, CH = 6, AUX = 6, SYS = 10, LONG = 40, RST = 12, MD = 2;
    logic clk = 1'b0, rst_n = 1'b0, uvok = 1'b0, req = 1'b0, btn_n = 1'b1;
    logic host_en = 1'b0, hold_off = 1'b0;
    logic power_hold, sysreq, sys_good, aon, sys_en, prst_n, aux_b;
    logic [5:0] en, good;
    logic [3:0] spare;
    logic [9:0] outs;
    int failures = 0, total_checks = 0, cycles = 0;
    // bit 0 always-on, 1..6 chain, 7 aux b, 8 system, 9 processor reset
    assign outs = {prst_n, sys_en, aux_b, en, aon};

    rss_sequencer #(.AON_CYC_P(28'(AON)), .LEAD_CYC_P(28'(LEAD)), .CHAIN_CYC_P(28'(CH)), .AUX_CYC_P(28'(AUX)),
        .SYS_CYC_P(28'(SYS)), .LONG_CYC_P(28'(LONG)), .RST_CYC_P(28'(RST))) u_rss_sequencer (
        .clk(clk), .rst_n(rst_n), .input_undervoltage_ok(uvok), .power_on_request(req),
        .power_hold(power_hold), .system_rail_request(sysreq), .push_button_n(btn_n),
        .lead_rail_good(good[0]), .second_rail_good(good[1]), .third_rail_good(good[2]),
        .fourth_rail_good(good[3]), .fifth_rail_good(good[4]), .system_rail_good(sys_good),
        .always_on_rail_en(aon), .lead_rail_en(en[0]), .second_rail_en(en[1]), .third_rail_en(en[2]),
        .fourth_rail_en(en[3]), .fifth_rail_en(en[4]), .aux_rail_a_en(en[5]), .aux_rail_b_en(aux_b),
        .system_rail_en(sys_en), .spare_rail_en(spare), .processor_reset_n(prst_n));
    rss_rail_model u_rss_rail_model (.clk(clk), .rst_n(rst_n), .chain_en(en), .sys_en(sys_en),
        .host_en(host_en), .hold_off(hold_off), .chain_good(good), .sys_good(sys_good),
        .power_hold(power_hold), .system_rail_request(sysreq));

    ////////////////////////////////////////////////////////////////
    always #10 clk = ~clk;
    // ceiling well above the ~320 cycles of the full run
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            failures++;
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////////
    task automatic check_lvl(input string name, input logic [9:0] exp, input logic [9:0] got);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : check_lvl

    task automatic check_range(input string name, input int lo, input int hi, input int got);
        total_checks++;
        if (got < lo || got > hi)
        begin
            failures++;
            $display("MISMATCH %s expected %0d..%0d seen %0d", name, lo, hi, got);
        end
    endtask : check_range

    // counts cycles until an output reaches a level; tolerance covers sync jitter
    task automatic wait_for(input int idx, input logic val, input int lo, input int hi, input string name);
        int n;
        logic v;
        n = 0;
        v = outs[idx];
        while (v !== val && n < hi + 5)
        begin
            @(posedge clk);
            #1;
            n++;
            v = outs[idx];
        end
        check_range(name, lo, hi, n);
    endtask : wait_for

    task automatic chain_up();
        for (int i = 2; i <= 4; i++)
            wait_for(i, 1'b1, MD + CH + 2, MD + CH + 6, "chain_step");
        wait_for(5, 1'b1, MD + 3, MD + 7, "fifth_rail_en");
        fork
            wait_for(6, 1'b1, MD + AUX + 2, MD + AUX + 6, "aux_rail_a_en");
            wait_for(9, 1'b1, MD + RST + 2, MD + RST + 6, "processor_reset_n");
        join
    endtask : chain_up

    ////////////////////////////////////////////////////////////////
    task automatic t_startup();
        uvok = 1'b1;
        wait_for(0, 1'b1, AON + 3, AON + 7, "always_on_rail_en");
        req = 1'b1;
        wait_for(1, 1'b1, LEAD + 3, LEAD + 7, "lead_rail_en");
        chain_up();
        check_lvl("spare_rail_en", 10'h000, {6'h00, spare});
    endtask : t_startup

    task automatic t_latch();
        req = 1'b0;
        repeat (20) @(posedge clk);
        #1;
        check_lvl("latched_rails", 10'h07f, {3'h0, outs[6:0]});
    endtask : t_latch

    task automatic t_sysrail();
        host_en = 1'b1;
        wait_for(8, 1'b1, SYS + 3, SYS + 7, "system_rail_en");
        wait_for(7, 1'b1, MD + AUX + 2, MD + AUX + 6, "aux_rail_b_en");
        host_en = 1'b0;
        wait_for(8, 1'b0, 2, 7, "system_rail_off");
    endtask : t_sysrail

    task automatic t_short();
        // a short press only acts once the button is let go
        btn_n = 1'b0;
        repeat (10) @(posedge clk);
        #1;
        check_lvl("reset_during_press", 10'h001, {9'h000, prst_n});
        btn_n = 1'b1;
        wait_for(9, 1'b0, 3, 7, "reset_low");
        wait_for(9, 1'b1, RST - 1, RST + 4, "reset_release");
        check_lvl("rails_after_short", 10'h07f, {3'h0, outs[6:0]});
    endtask : t_short

    task automatic t_long();
        btn_n = 1'b0;
        wait_for(1, 1'b0, LONG + 2, LONG + 7, "long_press_off");
        // always-on and reset follow the held state one edge later
        @(posedge clk);
        #1;
        check_lvl("all_outputs_off", 10'h000, outs);
        btn_n = 1'b1;
        wait_for(1, 1'b1, LEAD + 2, LEAD + 8, "restart_lead");
        chain_up();
    endtask : t_long

    task automatic t_hold_off();
        hold_off = 1'b1;
        wait_for(1, 1'b0, 2, 7, "hold_low_off");
        check_lvl("rails_after_hold", 10'h001, {3'h0, outs[6:0]});
    endtask : t_hold_off

    ////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        if (failures == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : wrap_up

    // main sequence: reset five cycles, then each scenario in turn
    initial
    begin
        repeat (5) @(posedge clk);
        #1;
        rst_n = 1'b1;
        t_startup();
        t_latch();
        t_sysrail();
        t_short();
        t_long();
        t_hold_off();
        wrap_up();
    end
endmodule : rail_startup_sequencer_test

// File: rss_pkg.sv
package rss_pkg;

    // timebase
    localparam int unsigned CLK_MHZ = 50;
    localparam int CW = 28;

    // documented delays, in their own units
    localparam int unsigned T_AON_US = 400;
    localparam int unsigned T_LEAD_US = 32000;
    localparam int unsigned T_CHAIN_US = 1000;
    localparam int unsigned T_FIFTH_US = 0;
    localparam int unsigned T_AUX_US = 1000;
    localparam int unsigned T_SYS_US = 2000;
    localparam int unsigned T_LONG_MS = 4000;
    localparam int unsigned T_RST_MS = 40;

    // cycle counts, least times, never below one cycle
    localparam logic [CW-1:0] AON_CYC = CW'(T_AON_US * CLK_MHZ);
    localparam logic [CW-1:0] LEAD_CYC = CW'(T_LEAD_US * CLK_MHZ);
    localparam logic [CW-1:0] CHAIN_CYC = CW'(T_CHAIN_US * CLK_MHZ);
    localparam logic [CW-1:0] FIFTH_CYC = (T_FIFTH_US * CLK_MHZ > 0) ? CW'(T_FIFTH_US * CLK_MHZ) : CW'(1);
    localparam logic [CW-1:0] AUX_CYC = CW'(T_AUX_US * CLK_MHZ);
    localparam logic [CW-1:0] SYS_CYC = CW'(T_SYS_US * CLK_MHZ);
    localparam logic [CW-1:0] LONG_CYC = CW'(T_LONG_MS * CLK_MHZ * 1000);
    localparam logic [CW-1:0] RST_CYC = CW'(T_RST_MS * CLK_MHZ * 1000);

    // positions of the synchronised pin inputs
    localparam int NIN = 11;
    localparam int IN_UVOK = 0;
    localparam int IN_REQ = 1;
    localparam int IN_HOLD = 2;
    localparam int IN_SYSREQ = 3;
    localparam int IN_BTN = 4;
    localparam int IN_GLEAD = 5;
    localparam int IN_GFIFTH = 9;
    localparam int IN_GSYS = 10;
    // reset image of the synchronisers: button reads released
    localparam logic [NIN-1:0] SYNC_RST = 11'h010;

    // chain rails lead..aux_a as a thermometer
    localparam int NCH = 6;
    localparam logic [NCH-1:0] CHAIN_OFF = 6'h00;
    localparam logic [3:0] SPARE_OFF = 4'h0;

    typedef enum logic [1:0] {ST_IDLE, ST_START, ST_RUN, ST_HELD} rss_state_e;

endpackage : rss_pkg

// File: rss_rail_model.sv
`timescale 1ns/1ps
module rss_rail_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [5:0] chain_en,
    input wire logic sys_en,
    input wire logic host_en,
    input wire logic hold_off,
    output logic [5:0] chain_good,
    output logic sys_good,
    output logic power_hold,
    output logic system_rail_request
);
    logic [6:0] stage_q;
    logic [6:0] good_q;
    // rails come good two cycles after enable; a dropped rail loses good one cycle later
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage_q <= 7'h00;
            good_q <= 7'h00;
        end
        else
        begin
            stage_q <= {sys_en, chain_en};
            good_q <= stage_q & {sys_en, chain_en};
        end
    end
    assign chain_good = good_q[5:0];
    assign sys_good = good_q[6];
    // hold is tied to the lead rail; the bench may pull it low
    assign power_hold = good_q[0] & ~hold_off;
    assign system_rail_request = host_en & good_q[4] & power_hold;
endmodule : rss_rail_model

// File: rss_sequencer.sv
`timescale 1ns/1ps
// Contract
// R01 - always-on rail turns on 400 us after input undervoltage ok
// R02 - power-on request high enables lead rail after 32000 us
// R03 - second/third/fourth follow previous good by 1000 us, fifth by 0 us
// R04 - aux A 1000 us after fifth good, aux B after system good
// R05 - lead good with power hold high latches chain and aux rails on
// R06 - system rail enable is hold AND request, after 2000 us
// R07 - system rail off at once when hold or request drops
// R08 - chain shuts down on 4 s button press or hold low with request low
// R09 - short button press pulls processor reset low, rails stay up
// R10 - long press powers down all outputs, restart sequence on release
// R11 - four spare rails stay disabled with no trigger
// R12 - host raises system request only after chain is good and hold high
// R13 - processor reset held low until 40 ms after fifth rail good
// R14 - press shorter than threshold is short, longer is long, never both
module rss_sequencer
    import rss_pkg::*;
#(
    parameter logic [rss_pkg::CW-1:0] AON_CYC_P = rss_pkg::AON_CYC,
    parameter logic [rss_pkg::CW-1:0] LEAD_CYC_P = rss_pkg::LEAD_CYC,
    parameter logic [rss_pkg::CW-1:0] CHAIN_CYC_P = rss_pkg::CHAIN_CYC,
    parameter logic [rss_pkg::CW-1:0] AUX_CYC_P = rss_pkg::AUX_CYC,
    parameter logic [rss_pkg::CW-1:0] SYS_CYC_P = rss_pkg::SYS_CYC,
    parameter logic [rss_pkg::CW-1:0] LONG_CYC_P = rss_pkg::LONG_CYC,
    parameter logic [rss_pkg::CW-1:0] RST_CYC_P = rss_pkg::RST_CYC
)(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic input_undervoltage_ok,
    input wire logic power_on_request,
    input wire logic power_hold,
    input wire logic system_rail_request,
    input wire logic push_button_n,
    input wire logic lead_rail_good,
    input wire logic second_rail_good,
    input wire logic third_rail_good,
    input wire logic fourth_rail_good,
    input wire logic fifth_rail_good,
    input wire logic system_rail_good,
    output logic always_on_rail_en,
    output logic lead_rail_en,
    output logic second_rail_en,
    output logic third_rail_en,
    output logic fourth_rail_en,
    output logic fifth_rail_en,
    output logic aux_rail_a_en,
    output logic aux_rail_b_en,
    output logic system_rail_en,
    output logic [3:0] spare_rail_en,
    output logic processor_reset_n
);
    import rss_pkg::*;

    // a press must be measurable and every delay at least one cycle
    if (AON_CYC_P == 0 || LEAD_CYC_P == 0 || CHAIN_CYC_P == 0 || AUX_CYC_P == 0 ||
        SYS_CYC_P == 0 || LONG_CYC_P < 2 || RST_CYC_P == 0)
    begin : g_bad_param
        $error("rss_sequencer: delay parameters out of range");
    end

    typedef struct packed {
        logic [NIN-1:0] s1;
        logic [NIN-1:0] s2;
        logic [NIN-1:0] s3;
        logic [NIN-1:0] f;
        rss_state_e st;
        logic [NCH-1:0] en;
        logic latch;
        logic restart;
        logic aon;
        logic sys;
        logic auxb;
        logic rst_out;
        logic [CW-1:0] aon_cnt;
        logic [CW-1:0] seq_cnt;
        logic [CW-1:0] sys_cnt;
        logic [CW-1:0] auxb_cnt;
        logic [CW-1:0] btn_cnt;
        logic [CW-1:0] rst_cnt;
    } rss_reg_s;

    rss_reg_s q, d;
    logic [NIN-1:0] pins;
    logic [NIN-1:0] agree;
    logic pressed;
    logic long_evt;
    logic short_evt;
    logic shutdown;
    logic [4:0] goods;
    logic [4:0] top;
    logic trig;
    logic [CW-1:0] stage_lim;

    ////////////////////////////////////////////////////////////////////////
    // pin inputs and derived events
    assign pins = {system_rail_good, fifth_rail_good, fourth_rail_good, third_rail_good,
                   second_rail_good, lead_rail_good, push_button_n, system_rail_request,
                   power_hold, power_on_request, input_undervoltage_ok};
    assign agree = ~(q.s2 ^ q.s3);
    assign pressed = ~q.f[IN_BTN];
    // R14 long press
    assign long_evt = pressed && (q.btn_cnt == LONG_CYC_P - CW'(1));
    // R14 short press
    assign short_evt = !pressed && (q.btn_cnt != '0) && (q.btn_cnt < LONG_CYC_P);
    // R08 hold dropped
    assign shutdown = q.latch && !q.f[IN_HOLD] && !q.f[IN_REQ];
    // highest enabled chain rail picks the next trigger
    assign goods = q.f[IN_GFIFTH:IN_GLEAD];
    assign top = q.en[4:0] & ~q.en[5:1];
    assign trig = |(goods & top);
    // R03 fifth follows fourth with no wait
    assign stage_lim = top[3] ? FIFTH_CYC : (top[4] ? AUX_CYC_P : CHAIN_CYC_P);

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        d = q;
        // three-stage sync, value moves only when stages two and three agree
        d.s1 = pins;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.f = (q.s3 & agree) | (q.f & ~agree);

        // button press timer, saturates at the long threshold
        if (pressed)
        begin
            if (q.btn_cnt != LONG_CYC_P)
                d.btn_cnt = q.btn_cnt + CW'(1);
        end
        else
            d.btn_cnt = '0;

        // R01 always-on rail
        if (q.f[IN_UVOK] && q.st != ST_HELD)
        begin
            if (q.aon_cnt != AON_CYC_P)
                d.aon_cnt = q.aon_cnt + CW'(1);
            d.aon = (q.aon_cnt == AON_CYC_P - CW'(1)) || q.aon;
        end
        else
        begin
            d.aon_cnt = '0;
            d.aon = 1'b0;
        end

        // main chain sequence
        case (q.st)
            ST_IDLE:
            begin
                d.en = CHAIN_OFF;
                d.seq_cnt = '0;
                if (q.f[IN_REQ])
                    d.st = ST_START;
            end
            ST_START:
            begin
                // R02 request must stay up through the lead delay, except on a restart after a long press
                d.seq_cnt = q.seq_cnt + CW'(1);
                if (!q.f[IN_REQ] && !q.restart)
                begin
                    d.st = ST_IDLE;
                    d.seq_cnt = '0;
                end
                else if (q.seq_cnt == LEAD_CYC_P - CW'(1))
                begin
                    // restart mark kept until the latch takes over
                    d.st = ST_RUN;
                    d.en = 6'h01;
                    d.seq_cnt = '0;
                end
            end
            ST_RUN:
            begin
                // R03 R04 each rail waits for its trigger good held long enough
                if (trig && !q.en[NCH-1])
                begin
                    d.seq_cnt = q.seq_cnt + CW'(1);
                    if (q.seq_cnt == stage_lim - CW'(1))
                    begin
                        d.en = {q.en[NCH-2:0], 1'b1};
                        d.seq_cnt = '0;
                    end
                end
                else
                    d.seq_cnt = '0;
                // R05 latch once lead is good with hold high
                if (q.f[IN_GLEAD] && q.f[IN_HOLD])
                begin
                    d.latch = 1'b1;
                    d.restart = 1'b0;
                end
                // R08 shutdown, also dropping the request before the latch
                // a restart after a long press runs without the request
                if (shutdown || (!q.latch && !q.restart && !q.f[IN_REQ]))
                begin
                    d.st = ST_IDLE;
                    d.en = CHAIN_OFF;
                    d.latch = 1'b0;
                    d.restart = 1'b0;
                    d.seq_cnt = '0;
                end
            end
            ST_HELD:
            begin
                // R10 all off until the button is released, then restart
                d.en = CHAIN_OFF;
                d.latch = 1'b0;
                d.seq_cnt = '0;
                if (!pressed)
                begin
                    d.st = ST_START;
                    d.restart = 1'b1;
                end
            end
            default:
            begin
                d.st = ST_IDLE;
                d.en = CHAIN_OFF;
            end
        endcase
        // R08 R10 long press wins over every other move
        if (long_evt)
        begin
            d.st = ST_HELD;
            d.en = CHAIN_OFF;
            d.latch = 1'b0;
            d.restart = 1'b0;
            d.seq_cnt = '0;
        end

        // R06 R07 system rail, dropped at once, gone during a long press
        if (q.f[IN_HOLD] && q.f[IN_SYSREQ] && q.st != ST_HELD && !long_evt)
        begin
            if (q.sys_cnt != SYS_CYC_P)
                d.sys_cnt = q.sys_cnt + CW'(1);
            d.sys = (q.sys_cnt == SYS_CYC_P - CW'(1)) || q.sys;
        end
        else
        begin
            d.sys_cnt = '0;
            d.sys = 1'b0;
        end

        // R04 aux B follows system good while the chain is up
        if (q.f[IN_GSYS] && d.en[0])
        begin
            if (q.auxb_cnt != AUX_CYC_P)
                d.auxb_cnt = q.auxb_cnt + CW'(1);
            d.auxb = (q.auxb_cnt == AUX_CYC_P - CW'(1)) || q.auxb;
        end
        else
        begin
            d.auxb_cnt = '0;
            d.auxb = 1'b0;
        end

        // R13 reset released 40 ms after fifth good
        if (q.f[IN_GFIFTH] && q.en[4])
        begin
            if (q.rst_cnt != RST_CYC_P)
                d.rst_cnt = q.rst_cnt + CW'(1);
            d.rst_out = (q.rst_cnt == RST_CYC_P - CW'(1)) || q.rst_out;
        end
        else
        begin
            d.rst_cnt = '0;
            d.rst_out = 1'b0;
        end
        // R09 short press restarts the reset pulse, rails untouched
        if (short_evt)
        begin
            d.rst_cnt = '0;
            d.rst_out = 1'b0;
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q <= '0;
            q.s1 <= SYNC_RST;
            q.s2 <= SYNC_RST;
            q.s3 <= SYNC_RST;
            q.f <= SYNC_RST;
            q.st <= ST_IDLE;
        end
        else
            q <= d;
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs straight from flip-flops, except the tied-off spare rails
    assign always_on_rail_en = q.aon;
    assign lead_rail_en = q.en[0];
    assign second_rail_en = q.en[1];
    assign third_rail_en = q.en[2];
    assign fourth_rail_en = q.en[3];
    assign fifth_rail_en = q.en[4];
    assign aux_rail_a_en = q.en[5];
    assign aux_rail_b_en = q.auxb;
    assign system_rail_en = q.sys;
    // R11 spare rails have no trigger
    assign spare_rail_en = SPARE_OFF;
    assign processor_reset_n = q.rst_out;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_aon_uv;
        !q.f[IN_UVOK] |=> !always_on_rail_en;
    endproperty
    a_aon_uv: assert property (p_aon_uv) else $error("always-on rail up without input ok"); // R01

    property p_lead_start;
        $rose(lead_rail_en) |-> $past(q.st) == ST_START && $past(q.seq_cnt) == LEAD_CYC_P - CW'(1);
    endproperty
    a_lead_start: assert property (p_lead_start) else $error("lead rail enabled outside start delay"); // R02

    property p_chain_order;
        $rose(second_rail_en) |-> $past(q.f[IN_GLEAD]) && lead_rail_en;
    endproperty
    a_chain_order: assert property (p_chain_order) else $error("second rail before lead good"); // R03

    property p_aux_a;
        $rose(aux_rail_a_en) |-> $past(q.f[IN_GFIFTH]) && fifth_rail_en;
    endproperty
    a_aux_a: assert property (p_aux_a) else $error("aux rail a before fifth good"); // R04

    property p_sys_on;
        $rose(system_rail_en) |-> $past(q.f[IN_HOLD] && q.f[IN_SYSREQ] && q.sys_cnt == SYS_CYC_P - CW'(1));
    endproperty
    a_sys_on: assert property (p_sys_on) else $error("system rail on without delay"); // R06

    property p_sys_off;
        !(q.f[IN_HOLD] && q.f[IN_SYSREQ]) |=> !system_rail_en;
    endproperty
    a_sys_off: assert property (p_sys_off) else $error("system rail stayed on"); // R07

    property p_hold_down;
        q.st == ST_RUN && shutdown && !long_evt |=> q.st == ST_IDLE && !lead_rail_en;
    endproperty
    a_hold_down: assert property (p_hold_down) else $error("chain not shut down on hold drop"); // R08

    property p_short;
        short_evt && lead_rail_en && q.st == ST_RUN && q.latch && !shutdown |=> !processor_reset_n && lead_rail_en;
    endproperty
    a_short: assert property (p_short) else $error("short press mishandled"); // R09

    property p_long;
        long_evt |=> q.st == ST_HELD ##1 !lead_rail_en && !always_on_rail_en && !system_rail_en;
    endproperty
    a_long: assert property (p_long) else $error("long press left outputs on"); // R10

    property p_rst;
        !fifth_rail_en |=> !processor_reset_n;
    endproperty
    a_rst: assert property (p_rst) else $error("processor reset released early"); // R13

    property p_latch;
        q.latch && q.f[IN_HOLD] && q.st == ST_RUN && !long_evt |=> q.st == ST_RUN && lead_rail_en;
    endproperty
    a_latch: assert property (p_latch) else $error("latched chain dropped"); // R05

endmodule : rss_sequencer
